// >>> rtl/pwr_budget_params.svh
`ifndef PWR_BUDGET_PARAMS_SVH
`define PWR_BUDGET_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define PB_OFS_HEADER 12'h20C
`define PB_OFS_SELECT 12'h210
`define PB_OFS_VALUE 12'h214
`define PB_OFS_INCL 12'h218
`define PB_OFS_PRELOAD_VAL 12'h300
`define PB_OFS_PRELOAD_INCL 12'h304

// ==========================================================
// Header fields
`define PB_CAP_ID 16'h0004
`define PB_CAP_VER 4'h1
`define PB_NEXT_UP 12'h230
`define PB_NEXT_DN 12'h220

// ==========================================================
// Index values and field defaults
`define PB_SEL_MAX 8'h00
`define PB_SEL_SUST 8'h01
`define PB_SEL_RST 8'h00
`define PB_WATT_RST 8'h04
`define PB_SCALE_RST 2'h0
`define PB_SUB_RST 3'h0
`define PB_LEVEL_RST 2'h0
`define PB_TYPE_MAX 3'h7
`define PB_TYPE_SUST 3'h3
`define PB_RAIL_RST 3'h2
`define PB_INCL_RST 1'h0

`endif

// >>> rtl/pwr_budget_pkg.sv
package pwr_budget_pkg;

	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] watt;
		logic [1:0] scale;
		logic [1:0] level;
		logic incl;
		logic [31:0] rdata;
		logic [1:0] up_sync;
	} state_s;

endpackage

// >>> rtl/power_budget_capability_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_budget_params.svh"

// How it works
// - Header low half reads capability ID 0004
// - Header bits 19:16 read version one
// - Next pointer 230h upstream, 220h downstream
// - Selector holds eight-bit index, resets zero
// - Index zero maximum, index one sustained
// - Other index values read all zero
// - Bits 7:0 base wattage, default 04h
// - Bits 9:8 scale, default 00b
// - Bits 12:10 sub-state, default 000b
// - Bits 14:13 power level, default 00b
// - Bits 17:15 condition type, 111b at index zero, 011b at index one
// - Bits 20:18 supply rail, default 010b
// - Management preload replaces wattage, scale, level and inclusion defaults, software read-only
// - Inclusion bit read-only, resets zero
module power_budget_capability_regs (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Port role pin, high on upstream port
	input wire logic upstream_i,
	// Software register port
	input wire logic [11:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Management preload port
	input wire logic mgmt_wr_i,
	input wire logic [11:0] mgmt_addr_i,
	input wire logic [31:0] mgmt_wdata_i
);

	// ==========================================================
	// State
	pwr_budget_pkg::state_s st_r;
	pwr_budget_pkg::state_s st_nxt;

	function automatic logic [31:0] entry_word(
		input logic [7:0] sel,
		input logic [7:0] watt,
		input logic [1:0] scale,
		input logic [1:0] level);
		logic [2:0] ctype;
		ctype = (sel == `PB_SEL_MAX) ? `PB_TYPE_MAX : `PB_TYPE_SUST;
		if (sel == `PB_SEL_MAX || sel == `PB_SEL_SUST) begin
			entry_word = {11'h0, `PB_RAIL_RST, ctype, level,
				`PB_SUB_RST, scale, watt};
		end else begin
			entry_word = 32'h00000000;
		end
	endfunction

	// ==========================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		// Role pin is a strap from outside, two flops before use
		st_nxt.up_sync = {st_r.up_sync[0], upstream_i};
		if (wr_i && addr_i == `PB_OFS_SELECT) begin
			st_nxt.sel = wdata_i[7:0];
		end
		// Only the management side can change these; software cannot
		if (mgmt_wr_i && mgmt_addr_i == `PB_OFS_PRELOAD_VAL) begin
			st_nxt.watt = mgmt_wdata_i[7:0];
			st_nxt.scale = mgmt_wdata_i[9:8];
			st_nxt.level = mgmt_wdata_i[14:13];
		end
		if (mgmt_wr_i && mgmt_addr_i == `PB_OFS_PRELOAD_INCL) begin
			st_nxt.incl = mgmt_wdata_i[0];
		end
		st_nxt.rdata = 32'h00000000;
		if (rd_i) begin
			case (addr_i)
				`PB_OFS_HEADER: begin
					st_nxt.rdata = {st_r.up_sync[1] ? `PB_NEXT_UP : `PB_NEXT_DN,
						`PB_CAP_VER, `PB_CAP_ID};
				end
				`PB_OFS_SELECT: begin
					st_nxt.rdata = {24'h000000, st_r.sel};
				end
				`PB_OFS_VALUE: begin
					st_nxt.rdata = entry_word(st_r.sel, st_r.watt,
						st_r.scale, st_r.level);
				end
				`PB_OFS_INCL: begin
					st_nxt.rdata = {31'h0, st_r.incl};
				end
				default: begin
					st_nxt.rdata = 32'h00000000;
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st_r.sel <= `PB_SEL_RST;
			st_r.watt <= `PB_WATT_RST;
			st_r.scale <= `PB_SCALE_RST;
			st_r.level <= `PB_LEVEL_RST;
			st_r.incl <= `PB_INCL_RST;
			st_r.rdata <= 32'h00000000;
			st_r.up_sync <= 2'h0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata_o = st_r.rdata;

	// ==========================================================
	// Checks
	property p_hdr_id;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_HEADER |=> rdata_o[19:0] == 20'h10004;
	endproperty
	a_hdr_id: assert property (p_hdr_id)
		else $error("bad header id");

	property p_hdr_ver;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_HEADER |=> rdata_o[19:16] == 4'h1;
	endproperty
	a_hdr_ver: assert property (p_hdr_ver)
		else $error("bad version");

	property p_next;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_HEADER && st_r.up_sync[1]
			|=> rdata_o[31:20] == 12'h230;
	endproperty
	a_next: assert property (p_next)
		else $error("bad next pointer");

	sequence s_sel_write;
		wr_i && addr_i == `PB_OFS_SELECT;
	endsequence
	property p_sel;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_sel_write ##1 (rd_i && addr_i == `PB_OFS_SELECT)
			|=> rdata_o == {24'h000000, $past(wdata_i[7:0], 2)};
	endproperty
	a_sel: assert property (p_sel)
		else $error("selector lost");

	property p_max;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_VALUE && st_r.sel == 8'h00
			|=> rdata_o[20:15] == 6'h17 && rdata_o[12:10] == 3'h0;
	endproperty
	a_max: assert property (p_max)
		else $error("bad max entry");

	property p_unsup;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_VALUE && st_r.sel > 8'h01
			|=> rdata_o == 32'h00000000;
	endproperty
	a_unsup: assert property (p_unsup)
		else $error("unsupported not zero");

	property p_watt;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_VALUE && st_r.sel < 8'h02
			|=> rdata_o[14:0] == {$past(st_r.level), 3'h0,
				$past(st_r.scale), $past(st_r.watt)};
	endproperty
	a_watt: assert property (p_watt)
		else $error("bad wattage fields");

	property p_incl;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_INCL |=> rdata_o[31:1] == 31'h0
			&& rdata_o[0] == $past(st_r.incl);
	endproperty
	a_incl: assert property (p_incl)
		else $error("bad inclusion word");

	property p_ro;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		wr_i && !mgmt_wr_i |=> $stable(st_r.watt) && $stable(st_r.incl);
	endproperty
	a_ro: assert property (p_ro)
		else $error("software changed preset");

	// ==========================================================
	// Read and load sequences
	sequence s_hdr_read;
		rd_i && addr_i == `PB_OFS_HEADER;
	endsequence
	sequence s_sel_read;
		rd_i && addr_i == `PB_OFS_SELECT;
	endsequence
	sequence s_val_read;
		rd_i && addr_i == `PB_OFS_VALUE;
	endsequence
	sequence s_preset_load;
		mgmt_wr_i && mgmt_addr_i == `PB_OFS_PRELOAD_VAL;
	endsequence
	sequence s_incl_load;
		mgmt_wr_i && mgmt_addr_i == `PB_OFS_PRELOAD_INCL;
	endsequence

	property p_hdr_low;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_hdr_read |=> rdata_o[15:0] == 16'h0004;
	endproperty
	a_hdr_low: assert property (p_hdr_low)
		else $error("bad capability id");

	property p_next_dn;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_HEADER && !st_r.up_sync[1]
			|=> rdata_o[31:20] == 12'h220;
	endproperty
	a_next_dn: assert property (p_next_dn)
		else $error("bad downstream pointer");

	property p_sel_rsvd;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_sel_read |=> rdata_o[31:8] == 24'h000000;
	endproperty
	a_sel_rsvd: assert property (p_sel_rsvd)
		else $error("selector reserved bits set");

	property p_val_rsvd;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_val_read |=> rdata_o[31:21] == 11'h0;
	endproperty
	a_val_rsvd: assert property (p_val_rsvd)
		else $error("value reserved bits set");

	property p_sust;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_VALUE && st_r.sel == 8'h01
			|=> rdata_o[20:15] == 6'h13 && rdata_o[12:10] == 3'h0;
	endproperty
	a_sust: assert property (p_sust)
		else $error("bad sustained entry");

	property p_scale;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_VALUE && st_r.sel < 8'h02
			|=> rdata_o[9:8] == $past(st_r.scale);
	endproperty
	a_scale: assert property (p_scale)
		else $error("bad scale field");

	property p_sub;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_VALUE && st_r.sel < 8'h02
			|=> rdata_o[12:10] == 3'h0;
	endproperty
	a_sub: assert property (p_sub)
		else $error("bad sub-state field");

	property p_level;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_VALUE && st_r.sel < 8'h02
			|=> rdata_o[14:13] == $past(st_r.level);
	endproperty
	a_level: assert property (p_level)
		else $error("bad power level field");

	property p_type;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_VALUE && st_r.sel == 8'h00
			|=> rdata_o[17:15] == 3'h7;
	endproperty
	a_type: assert property (p_type)
		else $error("bad condition type");

	property p_rail;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i == `PB_OFS_VALUE && st_r.sel < 8'h02
			|=> rdata_o[20:18] == 3'h2;
	endproperty
	a_rail: assert property (p_rail)
		else $error("bad supply rail");

	property p_unmapped;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		rd_i && addr_i != `PB_OFS_HEADER && addr_i != `PB_OFS_SELECT
			&& addr_i != `PB_OFS_VALUE && addr_i != `PB_OFS_INCL
			|=> rdata_o == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_sel_load;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_sel_write |=> st_r.sel == $past(wdata_i[7:0]);
	endproperty
	a_sel_load: assert property (p_sel_load)
		else $error("selector not loaded");

	property p_sel_hold;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		!(wr_i && addr_i == `PB_OFS_SELECT)
			|=> $stable(st_r.sel);
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("selector moved without write");

	property p_preset_load;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_preset_load |=> st_r.watt == $past(mgmt_wdata_i[7:0])
			&& st_r.scale == $past(mgmt_wdata_i[9:8])
			&& st_r.level == $past(mgmt_wdata_i[14:13]);
	endproperty
	a_preset_load: assert property (p_preset_load)
		else $error("preset not loaded");

	property p_preset_hold;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		!(mgmt_wr_i && mgmt_addr_i == `PB_OFS_PRELOAD_VAL)
			|=> $stable(st_r.watt) && $stable(st_r.scale)
			&& $stable(st_r.level);
	endproperty
	a_preset_hold: assert property (p_preset_hold)
		else $error("preset moved without load");

	property p_incl_load;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_incl_load |=> st_r.incl == $past(mgmt_wdata_i[0]);
	endproperty
	a_incl_load: assert property (p_incl_load)
		else $error("inclusion not loaded");

	property p_incl_hold;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		!(mgmt_wr_i && mgmt_addr_i == `PB_OFS_PRELOAD_INCL)
			|=> $stable(st_r.incl);
	endproperty
	a_incl_hold: assert property (p_incl_hold)
		else $error("inclusion moved without load");

	property p_rst_dflt;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> st_r.sel == 8'h00 && st_r.watt == 8'h04
			&& st_r.scale == 2'h0 && st_r.level == 2'h0
			&& st_r.incl == 1'h0;
	endproperty
	a_rst_dflt: assert property (p_rst_dflt)
		else $error("bad defaults after reset");

	property p_val_zero;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		s_sel_write ##1 s_val_read |=> (rdata_o == 32'h00000000)
			== ($past(wdata_i[7:0], 2) > 8'h01);
	endproperty
	a_val_zero: assert property (p_val_zero)
		else $error("zero budget mismatch");

endmodule
`default_nettype wire

// >>> verif/power_budget_capability_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwr_budget_params.svh"
module power_budget_capability_regs_tb_top;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic upstream_i = 1'b1;
	logic [11:0] addr_i = 12'h000;
	logic [11:0] mgmt_addr_i = 12'h000;
	logic [31:0] wdata_i = 32'h0;
	logic [31:0] mgmt_wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic mgmt_wr_i = 1'b0;
	logic [31:0] rdata_o;
	logic [31:0] r;
	logic [7:0] sel, watt;
	logic [1:0] scale, level;
	logic incl;
	logic [7:0] corner [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
	integer errors = 0;
	integer n_checks = 0;
	integer seed = 32'h0E54;

	always #2 clk_sys_i = ~clk_sys_i;

	power_budget_capability_regs i_power_budget_capability_regs (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.upstream_i(upstream_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.mgmt_wr_i(mgmt_wr_i), .mgmt_addr_i(mgmt_addr_i),
		.mgmt_wdata_i(mgmt_wdata_i));

	// ====
	// Helpers
	function automatic logic [31:0] exp_val(input logic [7:0] s);
		if (s > 8'h01)
			return 32'h0;
		return {11'h0, 3'h2, (s == 8'h00) ? 3'h7 : 3'h3, level, 3'h0,
			scale, watt};
	endfunction

	task automatic chk(input string n, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// Strobe left high for a gapless next write; next task drops it
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		mgmt_wr_i <= 1'b0;
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_sys_i);
	endtask

	task automatic mg(input logic [11:0] a, input logic [31:0] d);
		wr_i <= 1'b0;
		mgmt_wr_i <= 1'b1;
		mgmt_addr_i <= a;
		mgmt_wdata_i <= d;
		@(posedge clk_sys_i);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		wr_i <= 1'b0;
		mgmt_wr_i <= 1'b0;
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(posedge clk_sys_i);
		chk($sformatf("reg_%h", a), rdata_o, e);
	endtask

	task automatic do_reset;
		sys_rst_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		// Role strap needs two edges through its synchroniser
		repeat (2) @(posedge clk_sys_i);
		{watt, scale, level, incl} = {8'h04, 2'h0, 2'h0, 1'b0};
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ====
	// Tests
	initial begin
		do_reset;
		rd(`PB_OFS_HEADER, 32'h23010004);
		rd(`PB_OFS_SELECT, 32'h0);
		rd(`PB_OFS_VALUE, exp_val(8'h00));
		rd(`PB_OFS_INCL, 32'h0);
		$display("defaults done");
		wr(`PB_OFS_HEADER, 32'hFFFFFFFF);
		wr_i <= 1'b0;
		upstream_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rd(`PB_OFS_HEADER, 32'h22010004);
		upstream_i <= 1'b1;
		$display("header done");
		// Corners first, then random indices with junk upper bits
		for (int i = 0; i < 24; i++) begin
			r = $random(seed);
			sel = (i < 4) ? corner[i] : r[7:0];
			r[7:0] = sel;
			wr(`PB_OFS_SELECT, r);
			rd(`PB_OFS_SELECT, {24'h0, sel});
			rd(`PB_OFS_VALUE, exp_val(sel));
		end
		$display("selector done");
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			mg(`PB_OFS_PRELOAD_VAL, r);
			mg(`PB_OFS_PRELOAD_INCL, r);
			{level, scale, watt, incl} = {r[14:13], r[9:8], r[7:0], r[0]};
			wr(`PB_OFS_VALUE, ~r);
			wr(`PB_OFS_INCL, 32'hFFFFFFFF);
			wr(`PB_OFS_SELECT, 32'h0);
			rd(`PB_OFS_VALUE, exp_val(8'h00));
			wr(`PB_OFS_SELECT, 32'h1);
			rd(`PB_OFS_VALUE, exp_val(8'h01));
			rd(`PB_OFS_INCL, {31'h0, incl});
		end
		$display("preload done");
		rd(12'h000, 32'h0);
		do_reset;
		rd(`PB_OFS_VALUE, exp_val(8'h00));
		rd(`PB_OFS_SELECT, 32'h0);
		rd(`PB_OFS_INCL, 32'h0);
		$display("reset done");
		wrap_up;
	end

	initial begin
		#20000;
		errors++;
		wrap_up;
	end
endmodule
`default_nettype wire
